// file: rtl/saf_pkg.sv
package saf_pkg;

  localparam int unsigned SAF_ADDR_W = 16;
  localparam int unsigned SAF_DATA_W = 8;

  // Register offsets
  localparam logic [15:0] SAF_PD_CTRL_A_OFS = 16'h00c8;
  localparam logic [15:0] SAF_PD_CTRL_B_OFS = 16'h00c9;
  localparam logic [15:0] SAF_PD_CTRL_C_OFS = 16'h00ca;
  localparam logic [15:0] SAF_PD_CTRL_D_OFS = 16'h00cb;
  localparam logic [15:0] SAF_IRQ_EN_OFS = 16'h00c7;
  localparam logic [15:0] SAF_STATUS_OFS = 16'h0200;
  localparam logic [15:0] SAF_SPARE_A_OFS = 16'h0201;
  localparam logic [15:0] SAF_SPARE_B_OFS = 16'h0202;
  localparam logic [15:0] SAF_SPARE_C_OFS = 16'h0203;

  // Field positions
  localparam int unsigned SAF_LOCK_LOSS_BIT = 6;
  localparam int unsigned SAF_HOLDOVER_BIT = 4;
  localparam int unsigned SAF_SIG_LOSS1_BIT = 1;
  localparam int unsigned SAF_SIG_LOSS0_BIT = 0;

  // Reset values and reserved-bit read value
  localparam logic [7:0] SAF_STATUS_RST = 8'h00;
  localparam logic [7:0] SAF_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] SAF_RSVD_READ = 8'h00;

  // Loss-of-signal period count
  localparam int unsigned SAF_LOS_CNT_W = 17;
  localparam int unsigned SAF_LOS_CNT_MIN = 3;

  // Alarm sources in one group
  typedef struct packed {
    logic lock_loss;
    logic holdover;
    logic sig_loss_in1;
    logic sig_loss_in0;
  } saf_alarm_s;

  // Host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } saf_host_req_s;

endpackage : saf_pkg

// file: rtl/saf_sticky_flags.sv
// Functional notes
// - Each alarm's onset sets its own dedicated status flag.
// - A set flag stays set after its alarm disappears.
// - Only a host write of one to the bit clears the flag.
// - Lock-loss flag is bit 6 of status byte 0200, reset zero.
// - Holdover flag is bit 4 of status byte 0200, reset zero.
// - Signal-loss flags for inputs 1 and 0 at bits 1, 0, reset zero.
// - Host writes zero to reserved bits; their reads are undefined.
// - Enable bits at 00C7 gate each flag onto the low interrupt.
// - Signal loss raised after a programmed period count, minimum three; here the count only drives los_count_bad_o when below three.
`timescale 1ns/1ps
`default_nettype none

module saf_sticky_flags
  import saf_pkg::*;
#(
  parameter int unsigned LOS_CNT_W = SAF_LOS_CNT_W
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire saf_alarm_s alarm_i,
  input wire saf_host_req_s host_req_i,
  input wire logic [LOS_CNT_W-1:0] missing_ref_period_count_i,
  output logic [7:0] host_rdata_o,
  output logic irq_out_n_o,
  output logic los_count_bad_o
);

  // Elaboration check on the count width
  if (LOS_CNT_W < 2 || LOS_CNT_W > 32) begin : g_bad_cnt_w
    $error("saf_sticky_flags: LOS_CNT_W out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alarm onset detection
  saf_alarm_s alarm_prev_reg;
  saf_alarm_s alarm_rise;
  logic [3:0] alarm_vec;
  logic [3:0] prev_vec;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_prev_reg <= '0;
    end else begin
      alarm_prev_reg <= alarm_i;
    end
  end

  assign alarm_vec = alarm_i;
  assign prev_vec = alarm_prev_reg;
  assign alarm_rise = alarm_vec & ~prev_vec;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags
  logic lock_loss_flag_reg;
  logic holdover_flag_reg;
  logic signal_loss_flag_in1_reg;
  logic signal_loss_flag_in0_reg;
  logic status_wr;
  logic [7:0] w1c;

  assign status_wr = host_req_i.wr && (host_req_i.addr == SAF_STATUS_OFS);
  assign w1c = status_wr ? host_req_i.wdata : 8'h00;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_loss_flag_reg <= SAF_STATUS_RST[SAF_LOCK_LOSS_BIT];
      holdover_flag_reg <= SAF_STATUS_RST[SAF_HOLDOVER_BIT];
      signal_loss_flag_in1_reg <= SAF_STATUS_RST[SAF_SIG_LOSS1_BIT];
      signal_loss_flag_in0_reg <= SAF_STATUS_RST[SAF_SIG_LOSS0_BIT];
    end else begin
      // Set wins over clear; held otherwise
      lock_loss_flag_reg <= alarm_rise.lock_loss
        | (lock_loss_flag_reg & ~w1c[SAF_LOCK_LOSS_BIT]);
      holdover_flag_reg <= alarm_rise.holdover
        | (holdover_flag_reg & ~w1c[SAF_HOLDOVER_BIT]);
      signal_loss_flag_in1_reg <= alarm_rise.sig_loss_in1
        | (signal_loss_flag_in1_reg & ~w1c[SAF_SIG_LOSS1_BIT]);
      signal_loss_flag_in0_reg <= alarm_rise.sig_loss_in0
        | (signal_loss_flag_in0_reg & ~w1c[SAF_SIG_LOSS0_BIT]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt enables
  logic lock_loss_irq_enable_reg;
  logic holdover_irq_enable_reg;
  logic signal_loss_irq_enable_in1_reg;
  logic signal_loss_irq_enable_in0_reg;
  logic en_wr;

  assign en_wr = host_req_i.wr && (host_req_i.addr == SAF_IRQ_EN_OFS);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_loss_irq_enable_reg <= SAF_IRQ_EN_RST[SAF_LOCK_LOSS_BIT];
      holdover_irq_enable_reg <= SAF_IRQ_EN_RST[SAF_HOLDOVER_BIT];
      signal_loss_irq_enable_in1_reg <= SAF_IRQ_EN_RST[SAF_SIG_LOSS1_BIT];
      signal_loss_irq_enable_in0_reg <= SAF_IRQ_EN_RST[SAF_SIG_LOSS0_BIT];
    end else if (en_wr) begin
      lock_loss_irq_enable_reg <= host_req_i.wdata[SAF_LOCK_LOSS_BIT];
      holdover_irq_enable_reg <= host_req_i.wdata[SAF_HOLDOVER_BIT];
      signal_loss_irq_enable_in1_reg <= host_req_i.wdata[SAF_SIG_LOSS1_BIT];
      signal_loss_irq_enable_in0_reg <= host_req_i.wdata[SAF_SIG_LOSS0_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt output
  logic irq_any;

  assign irq_any = (lock_loss_flag_reg & lock_loss_irq_enable_reg)
    | (holdover_flag_reg & holdover_irq_enable_reg)
    | (signal_loss_flag_in1_reg & signal_loss_irq_enable_in1_reg)
    | (signal_loss_flag_in0_reg & signal_loss_irq_enable_in0_reg);
  assign irq_out_n_o = ~irq_any;

  //////////////////////////////////////////////////////////////////////////////
  // Loss-of-signal count check
  assign los_count_bad_o = (32'(missing_ref_period_count_i) < SAF_LOS_CNT_MIN);

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [7:0] status_byte;
  logic [7:0] enable_byte;
  logic [7:0] rdata_next;

  always_comb begin
    status_byte = SAF_RSVD_READ;
    status_byte[SAF_LOCK_LOSS_BIT] = lock_loss_flag_reg;
    status_byte[SAF_HOLDOVER_BIT] = holdover_flag_reg;
    status_byte[SAF_SIG_LOSS1_BIT] = signal_loss_flag_in1_reg;
    status_byte[SAF_SIG_LOSS0_BIT] = signal_loss_flag_in0_reg;
    enable_byte = SAF_RSVD_READ;
    enable_byte[SAF_LOCK_LOSS_BIT] = lock_loss_irq_enable_reg;
    enable_byte[SAF_HOLDOVER_BIT] = holdover_irq_enable_reg;
    enable_byte[SAF_SIG_LOSS1_BIT] = signal_loss_irq_enable_in1_reg;
    enable_byte[SAF_SIG_LOSS0_BIT] = signal_loss_irq_enable_in0_reg;
  end

  always_comb begin
    unique case (host_req_i.addr)
      SAF_STATUS_OFS: rdata_next = status_byte;
      SAF_IRQ_EN_OFS: rdata_next = enable_byte;
      default: rdata_next = SAF_RSVD_READ;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_rdata_o <= 8'h00;
    end else if (host_req_i.rd) begin
      host_rdata_o <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sticky_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(alarm_i.lock_loss) |=> lock_loss_flag_reg)
    else $error("lock loss onset did not set flag");

  sticky_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    holdover_flag_reg && !(status_wr && host_req_i.wdata[SAF_HOLDOVER_BIT])
    |=> holdover_flag_reg)
    else $error("holdover flag dropped without clear");

  w1c_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    status_wr && host_req_i.wdata[SAF_SIG_LOSS0_BIT] && !$rose(alarm_i.sig_loss_in0)
    |=> !signal_loss_flag_in0_reg)
    else $error("write one did not clear input 0 flag");

  lock_pos_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    host_req_i.rd && host_req_i.addr == SAF_STATUS_OFS
    |=> host_rdata_o[6] == $past(lock_loss_flag_reg))
    else $error("lock loss flag not at bit 6");

  hold_pos_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    host_req_i.rd && host_req_i.addr == SAF_STATUS_OFS
    |=> host_rdata_o[4] == $past(holdover_flag_reg))
    else $error("holdover flag not at bit 4");

  los_pos_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    host_req_i.rd && host_req_i.addr == SAF_STATUS_OFS
    |=> host_rdata_o[1:0] == $past({signal_loss_flag_in1_reg,
      signal_loss_flag_in0_reg}))
    else $error("signal loss flags misplaced");

  irq_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !lock_loss_irq_enable_reg && !holdover_irq_enable_reg
    && !signal_loss_irq_enable_in1_reg && !signal_loss_irq_enable_in0_reg
    |-> irq_out_n_o)
    else $error("interrupt asserted with all enables off");

  set_wins_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(alarm_i.holdover) && status_wr && host_req_i.wdata[SAF_HOLDOVER_BIT]
    |=> holdover_flag_reg && (!irq_out_n_o || !holdover_irq_enable_reg))
    else $error("clear beat a simultaneous set");

  count_min_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    missing_ref_period_count_i == 2 |-> los_count_bad_o)
    else $error("count two not flagged");

  rsvd_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    host_req_i.rd |=> {host_rdata_o[7], host_rdata_o[5], host_rdata_o[3:2]} == 4'h0)
    else $error("reserved bits read nonzero");

  set_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(alarm_i.holdover) ##1 holdover_flag_reg);
  clear_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    lock_loss_flag_reg ##1 !lock_loss_flag_reg);
  irq_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    $fell(irq_out_n_o));
  race_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(alarm_i.holdover) && status_wr && host_req_i.wdata[SAF_HOLDOVER_BIT]);
  held_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    alarm_i.lock_loss && !alarm_rise.lock_loss && status_wr);

endmodule : saf_sticky_flags

`default_nettype wire

// file: testbench/saf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Serial host side: one-cycle strobes, single bytes
module saf_host_model
  import saf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] host_rdata_i,
  output var saf_host_req_s host_req_o
);
  initial host_req_o = '0;

  // Reserved positions always written as zero
  task automatic wr_byte(input logic [15:0] addr, input logic [7:0] data);
    @(posedge mclk_i);
    host_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data & 8'h53};
    @(posedge mclk_i);
    host_req_o <= '0;
  endtask : wr_byte

  task automatic rd_byte(input logic [15:0] addr, output logic [7:0] data);
    @(posedge mclk_i);
    host_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge mclk_i);
    host_req_o <= '0;
    #1 data = host_rdata_i;
  endtask : rd_byte
endmodule : saf_host_model
`default_nettype wire

// file: testbench/test_sticky_alarm_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_sticky_alarm_status_flags
  import saf_pkg::*;
;
  logic mclk_i;
  logic resetn_i;
  saf_alarm_s alarm_i;
  saf_host_req_s host_req;
  logic [16:0] count_i;
  logic [7:0] rdata;
  logic irq_n;
  logic cnt_bad;
  logic [7:0] rd;
  int err_count = 0;
  int checks = 0;

  saf_sticky_flags dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .alarm_i(alarm_i),
    .host_req_i(host_req), .missing_ref_period_count_i(count_i), .host_rdata_o(rdata),
    .irq_out_n_o(irq_n), .los_count_bad_o(cnt_bad));
  saf_host_model host_u (.mclk_i(mclk_i), .host_rdata_i(rdata), .host_req_o(host_req));

  ////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic results();
    $display("checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic pulse(input saf_alarm_s a);
    @(posedge mclk_i);
    alarm_i <= a;
    @(posedge mclk_i);
    alarm_i <= '0;
  endtask : pulse

  // Alarm index to status bit position
  function automatic int pos(input int k);
    return (k < 2) ? k : 2 * k;
  endfunction : pos

  ////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    resetn_i = 1'b0;
    alarm_i = '0;
    count_i = 17'h00003;
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    host_u.rd_byte(SAF_STATUS_OFS, rd);
    check("status reset", 8'h00, rd);
    host_u.rd_byte(SAF_IRQ_EN_OFS, rd);
    check("enable reset", 8'h00, rd);
    check("irq reset", 8'h01, {7'h00, irq_n});
    for (int k = 0; k < 4; k++) begin
      pulse(saf_alarm_s'(4'(4'h1 << k)));
      host_u.rd_byte(SAF_STATUS_OFS, rd);
      check("flag sticky", 8'(8'h01 << pos(k)), rd);
      check("irq masked", 8'h01, {7'h00, irq_n});
      host_u.wr_byte(SAF_STATUS_OFS, 8'h00);
      host_u.rd_byte(SAF_STATUS_OFS, rd);
      check("zero write", 8'(8'h01 << pos(k)), rd);
      host_u.wr_byte(SAF_STATUS_OFS, 8'(8'h01 << pos(k)));
      host_u.rd_byte(SAF_STATUS_OFS, rd);
      check("flag cleared", 8'h00, rd);
    end
    host_u.wr_byte(SAF_IRQ_EN_OFS, 8'h53);
    host_u.rd_byte(SAF_IRQ_EN_OFS, rd);
    check("enable rw", 8'h53, rd);
    pulse('{lock_loss: 1'b0, holdover: 1'b1, sig_loss_in1: 1'b0, sig_loss_in0: 1'b0});
    @(posedge mclk_i);
    #1 check("irq asserted", 8'h00, {7'h00, irq_n});
    host_u.wr_byte(SAF_IRQ_EN_OFS, 8'h43);
    #1 check("irq disabled", 8'h01, {7'h00, irq_n});
    // Set and clear in the same cycle
    fork
      host_u.wr_byte(SAF_STATUS_OFS, 8'h10);
      pulse('{lock_loss: 1'b0, holdover: 1'b1, sig_loss_in1: 1'b0, sig_loss_in0: 1'b0});
    join
    host_u.rd_byte(SAF_STATUS_OFS, rd);
    check("set wins", 8'h10, rd);
    // Alarm held high sets once only
    @(posedge mclk_i);
    alarm_i <= '{lock_loss: 1'b1, holdover: 1'b0, sig_loss_in1: 1'b0, sig_loss_in0: 1'b0};
    host_u.wr_byte(SAF_STATUS_OFS, 8'h50);
    host_u.rd_byte(SAF_STATUS_OFS, rd);
    check("held alarm", 8'h00, rd);
    #1 check("irq released", 8'h01, {7'h00, irq_n});
    @(posedge mclk_i);
    alarm_i <= '0;
    // Reserved and unmapped places
    host_u.wr_byte(SAF_PD_CTRL_A_OFS, 8'hff);
    host_u.rd_byte(SAF_PD_CTRL_A_OFS, rd);
    check("reserved ctrl", SAF_RSVD_READ, rd);
    host_u.rd_byte(SAF_SPARE_B_OFS, rd);
    check("reserved spare", SAF_RSVD_READ, rd);
    host_u.rd_byte(16'h0100, rd);
    check("unmapped", 8'h00, rd);
    // Period count minimum
    @(posedge mclk_i);
    count_i <= 17'h00002;
    @(posedge mclk_i);
    #1 check("count two", 8'h01, {7'h00, cnt_bad});
    @(posedge mclk_i);
    count_i <= 17'h00003;
    @(posedge mclk_i);
    #1 check("count three", 8'h00, {7'h00, cnt_bad});
    results();
  end
endmodule : test_sticky_alarm_status_flags
`default_nettype wire
